// [common/cp_xfer_defs.vh]
`ifndef CP_XFER_DEFS_VH
`define CP_XFER_DEFS_VH

// ----------------------------------------
// apb register offsets (byte addresses)
// ----------------------------------------
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_SCAN        8'h08
`define OFS_COUNT       8'h0C

// ----------------------------------------
// register fields and reset values
// ----------------------------------------
`define CTRL_EN_BIT     0
`define CTRL_RESET      32'h0000_0001
`define ST_BUSY_BIT     0
`define ST_PV_BIT       1
`define ST_LF_BIT       2
`define SCAN_RESET      32'h0000_0000

// ----------------------------------------
// primitive word layout
// ----------------------------------------
`define PR_CA_BIT       15
`define PR_SC_BIT       14
`define PR_DIR_BIT      13
`define PR_TYPE_HI      12
`define PR_TYPE_LO      8
`define PT_CTRL_REG     5'h0D
`define PT_MULTI_MAIN   5'h06
`define PT_MULTI_COP    5'h01

// ----------------------------------------
// control register select codes (low 12 bits)
// ----------------------------------------
`define CS_SFC          12'h000
`define CS_DFC          12'h001
`define CS_CACHE_CTL    12'h002
`define CS_USP          12'h800
`define CS_VBR          12'h801
`define CS_CACHE_ADDR   12'h802
`define CS_MSP          12'h803
`define CS_ISP          12'h804

// ----------------------------------------
// interface register selects and values
// ----------------------------------------
`define CIR_SELECT      2'h0
`define CIR_OPERAND     2'h1
`define CIR_CONTROL     2'h2
`define ABORT_MASK      32'h0000_0001

// ----------------------------------------
// effective address modes
// ----------------------------------------
`define EA_POSTINC      3'h3
`define EA_PREDEC       3'h4
`define EA_SPECIAL      3'h7

`endif

// [verilog/main_reg_file.v]
`timescale 1ns/1ps
// ----------------------------------------
// data and address registers, 16 x 32
// ----------------------------------------
module main_reg_file (
  input  wire        i_clk,
  input  wire        i_we,
  input  wire [3:0]  i_waddr,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_raddr,
  output reg  [31:0] o_rdata
);
  reg [31:0] mem [0:15];

  // one write port, registered read one cycle after address
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // main_reg_file

// [verilog/coprocessor_register_transfer.v]
`timescale 1ns/1ps
`include "cp_xfer_defs.vh"
// Operation
// - control register primitive: flags 15-13, pattern 01101, low byte zero
// - flag clear in conditional instruction for register primitives: protocol violation
// - control register primitive first reads select code from select register
// - eight select codes map to the eight control registers
// - any other select code: protocol violation, no transfer
// - direction 0 writes control register to operand; 1 reads into it
// - multiple register primitive reads 16-bit mask; set bits select registers
// - order data 7 to 0, then address 7 to 0, both directions
// - direction 0 writes each register out; 1 reads each register in
// - coprocessor multiple primitive: flags, pattern 00001, byte length low byte
// - coprocessor multiple primitive in conditional instruction: protocol violation
// - odd operand length: protocol violation
// - compute address; scan counter grows two per extension word
// - valid modes: control or postincrement in, control alterable or predecrement out
// - invalid mode: abort mask to control register, then line-1111 exception
// - operand count is number of mask ones, position ignored
// - direction 1 stores operands to memory; 0 fetches them, long words first
// - ascending addresses; postincrement register grows by total bytes
// - predecrement lowers register before each operand; bytes ascend inside
module coprocessor_register_transfer (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_prim_valid,
  input  wire [15:0] i_prim,
  input  wire        i_conditional,
  input  wire [2:0]  i_ea_mode,
  input  wire [2:0]  i_ea_reg,
  input  wire [2:0]  i_ea_ext,
  input  wire [31:0] i_ea_addr,
  output reg         o_busy,
  output reg         o_done,
  output reg         o_proto_viol,
  output reg         o_line_f,
  output reg         o_cir_req,
  output reg         o_cir_write,
  output reg  [1:0]  o_cir_sel,
  output reg  [31:0] o_cir_wdata,
  input  wire        i_cir_ack,
  input  wire [31:0] i_cir_rdata,
  output reg         o_mem_req,
  output reg         o_mem_write,
  output reg  [31:0] o_mem_addr,
  output reg  [31:0] o_mem_wdata,
  input  wire        i_mem_ack,
  input  wire [31:0] i_mem_rdata,
  output reg         o_word
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] S_IDLE   = 4'h0;
  localparam [3:0] S_SEL    = 4'h1;
  localparam [3:0] S_CTRL   = 4'h2;
  localparam [3:0] S_MM_PICK = 4'h3;
  localparam [3:0] S_MM_RD  = 4'h4;
  localparam [3:0] S_MM_CIR = 4'h5;
  localparam [3:0] S_EA     = 4'h6;
  localparam [3:0] S_ABORT  = 4'h7;
  localparam [3:0] S_AN_RD  = 4'h8;
  localparam [3:0] S_OPND   = 4'h9;
  localparam [3:0] S_CHUNK  = 4'hA;
  localparam [3:0] S_MC_MEM = 4'hB;
  localparam [3:0] S_MC_CIR = 4'hC;
  localparam [3:0] S_WBACK  = 4'hD;
  localparam [31:0] CTRL_RST = `CTRL_RESET;

  reg  [3:0]  state;
  reg  [4:0]  ptype;
  reg         dir;
  reg  [7:0]  op_len;
  reg  [2:0]  mode;
  reg  [2:0]  areg_num;
  reg  [15:0] mask;
  reg  [3:0]  bitp;
  reg  [2:0]  csel;
  reg  [4:0]  ops_left;
  reg  [7:0]  bytes_left;
  reg  [31:0] cur_addr;
  reg  [31:0] an_val;
  reg  [31:0] xdata;
  reg  [31:0] creg [0:7];
  reg  [31:0] scan_counter;
  reg  [4:0]  op_count;
  reg         enable;
  reg         pv_flag;
  reg         lf_flag;
  reg         rf_we;
  reg  [3:0]  rf_waddr;
  reg  [31:0] rf_wdata;
  wire [31:0] rf_rdata;
  integer     k;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // mask bit 15..8 is d7..d0, 7..0 is a7..a0; file index 0..7 data, 8..15 address
  function [3:0] rf_index;
    input [3:0] b;
    begin
      rf_index = b[3] ? {1'b0, b[2:0]} : {1'b1, b[2:0]};
    end
  endfunction

  function [4:0] ones;
    input [15:0] m;
    integer j;
    begin
      ones = 5'h00;
      for (j = 0; j < 16; j = j + 1) begin
        ones = ones + {4'h0, m[j]};
      end
    end
  endfunction

  // select code to control register slot, bit 3 flags an invalid code
  function [3:0] ctrl_slot;
    input [11:0] c;
    begin
      if (c == `CS_SFC) ctrl_slot = 4'h0;
      else if (c == `CS_DFC) ctrl_slot = 4'h1;
      else if (c == `CS_CACHE_CTL) ctrl_slot = 4'h2;
      else if (c == `CS_USP) ctrl_slot = 4'h3;
      else if (c == `CS_VBR) ctrl_slot = 4'h4;
      else if (c == `CS_CACHE_ADDR) ctrl_slot = 4'h5;
      else if (c == `CS_MSP) ctrl_slot = 4'h6;
      else if (c == `CS_ISP) ctrl_slot = 4'h7;
      else ctrl_slot = 4'h8;
    end
  endfunction

  // control = modes 2,5,6 and 7/0..3; alterable drops the pc-relative 7/2,7/3
  function mode_ok;
    input [2:0] m;
    input [2:0] r;
    input       d;
    reg         ctl;
    begin
      ctl = (m == 3'h2) || (m == 3'h5) || (m == 3'h6) ||
            ((m == `EA_SPECIAL) && (r < 3'h4));
      if (d) begin
        mode_ok = (ctl && !((m == `EA_SPECIAL) && r[1])) || (m == `EA_PREDEC);
      end else begin
        mode_ok = ctl || (m == `EA_POSTINC);
      end
    end
  endfunction

  wire [4:0] in_type  = i_prim[`PR_TYPE_HI:`PR_TYPE_LO];
  wire       in_ca    = i_prim[`PR_CA_BIT];
  wire       take     = i_prim_valid && !o_busy && enable;
  wire       apb_wr   = i_psel && i_penable && o_pready && i_pwrite;
  wire       ctl_low0 = (i_prim[7:0] == 8'h00);
  wire [3:0] sel_slot = ctrl_slot(i_cir_rdata[11:0]);
  wire [3:0] rf_raddr = (state == S_EA) ? {1'b1, areg_num} : rf_index(bitp);

  main_reg_file u_rf (
    .i_clk   (i_clk),
    .i_we    (rf_we),
    .i_waddr (rf_waddr),
    .i_wdata (rf_wdata),
    .i_raddr (rf_raddr),
    .o_rdata (rf_rdata)
  );

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // no wait state: pready rises in the first access cycle
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      if (i_psel && !i_penable) begin
        if (i_paddr == `OFS_CTRL) begin
          o_prdata <= {31'h0000_0000, enable};
        end else if (i_paddr == `OFS_STATUS) begin
          o_prdata <= {24'h00_0000, state, 1'b0, lf_flag, pv_flag, o_busy};
        end else if (i_paddr == `OFS_SCAN) begin
          o_prdata <= scan_counter;
        end else if (i_paddr == `OFS_COUNT) begin
          o_prdata <= {27'h000_0000, op_count};
        end else begin
          o_pslverr <= 1'b1; // unmapped
        end
      end
    end
  end

  // ----------------------------------------
  // transfer engine
  // ----------------------------------------
  // sticky flags: a new event in the clear cycle wins over the clear
  always @(posedge i_clk) begin
    if (i_rst) begin
      state <= S_IDLE;
      ptype <= 5'h00;
      dir <= 1'b0;
      op_len <= 8'h00;
      mode <= 3'h0;
      areg_num <= 3'h0;
      mask <= 16'h0000;
      bitp <= 4'h0;
      csel <= 3'h0;
      ops_left <= 5'h00;
      bytes_left <= 8'h00;
      cur_addr <= 32'h0000_0000;
      an_val <= 32'h0000_0000;
      xdata <= 32'h0000_0000;
      scan_counter <= `SCAN_RESET;
      op_count <= 5'h00;
      enable <= CTRL_RST[`CTRL_EN_BIT];
      pv_flag <= 1'b0;
      lf_flag <= 1'b0;
      rf_we <= 1'b0;
      rf_waddr <= 4'h0;
      rf_wdata <= 32'h0000_0000;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_proto_viol <= 1'b0;
      o_line_f <= 1'b0;
      o_cir_req <= 1'b0;
      o_cir_write <= 1'b0;
      o_cir_sel <= `CIR_SELECT;
      o_cir_wdata <= 32'h0000_0000;
      o_mem_req <= 1'b0;
      o_mem_write <= 1'b0;
      o_mem_addr <= 32'h0000_0000;
      o_mem_wdata <= 32'h0000_0000;
      o_word <= 1'b0;
      for (k = 0; k < 8; k = k + 1) begin
        creg[k] <= 32'h0000_0000;
      end
    end else begin
      o_done <= 1'b0;
      o_proto_viol <= 1'b0;
      o_line_f <= 1'b0;
      rf_we <= 1'b0;
      // software side
      if (apb_wr && i_paddr == `OFS_CTRL) begin
        enable <= i_pwdata[`CTRL_EN_BIT];
      end
      if (apb_wr && i_paddr == `OFS_STATUS) begin
        if (i_pwdata[`ST_PV_BIT]) pv_flag <= 1'b0;
        if (i_pwdata[`ST_LF_BIT]) lf_flag <= 1'b0;
      end
      if (apb_wr && i_paddr == `OFS_SCAN && state == S_IDLE) begin
        scan_counter <= i_pwdata;
      end
      if (o_proto_viol) pv_flag <= 1'b1;
      if (o_line_f) lf_flag <= 1'b1;
      case (state)
        S_IDLE: begin
          if (take) begin
            ptype <= in_type;
            dir <= i_prim[`PR_DIR_BIT];
            op_len <= i_prim[7:0];
            mode <= i_ea_mode;
            areg_num <= i_ea_reg;
            if ((in_type == `PT_CTRL_REG && ctl_low0) || in_type == `PT_MULTI_MAIN) begin
              if (i_conditional && !in_ca) begin
                o_proto_viol <= 1'b1;
                o_done <= 1'b1;
              end else begin
                o_busy <= 1'b1;
                o_cir_req <= 1'b1;
                o_cir_write <= 1'b0;
                o_cir_sel <= `CIR_SELECT;
                state <= S_SEL;
              end
            end else if (in_type == `PT_MULTI_COP) begin
              if (i_conditional || i_prim[0]) begin
                o_proto_viol <= 1'b1;
                o_done <= 1'b1;
              end else begin
                o_busy <= 1'b1;
                state <= S_EA;
              end
            end else begin
              o_proto_viol <= 1'b1; // unknown to this block
              o_done <= 1'b1;
            end
          end
        end
        S_SEL: begin
          if (i_cir_ack) begin
            o_cir_req <= 1'b0;
            mask <= i_cir_rdata[15:0];
            csel <= sel_slot[2:0];
            bitp <= 4'hF;
            if (ptype == `PT_CTRL_REG) begin
              if (sel_slot[3]) begin
                o_proto_viol <= 1'b1;
                o_done <= 1'b1;
                o_busy <= 1'b0;
                state <= S_IDLE;
              end else begin
                o_cir_req <= 1'b1;
                o_cir_write <= !dir;
                o_cir_sel <= `CIR_OPERAND;
                o_cir_wdata <= creg[sel_slot[2:0]];
                state <= S_CTRL;
              end
            end else if (ptype == `PT_MULTI_MAIN) begin
              state <= S_MM_PICK;
            end else begin
              ops_left <= ones(i_cir_rdata[15:0]);
              op_count <= ones(i_cir_rdata[15:0]);
              if (ones(i_cir_rdata[15:0]) == 5'h00) begin
                o_done <= 1'b1;
                o_busy <= 1'b0;
                state <= S_IDLE;
              end else begin
                state <= S_OPND;
              end
            end
          end
        end
        S_CTRL: begin
          if (i_cir_ack) begin
            o_cir_req <= 1'b0;
            if (dir) creg[csel] <= i_cir_rdata;
            o_done <= 1'b1;
            o_busy <= 1'b0;
            state <= S_IDLE;
          end
        end
        // walk mask from d7 down to a0, one bit per cycle
        S_MM_PICK: begin
          if (mask[bitp]) begin
            if (dir) begin
              o_cir_req <= 1'b1;
              o_cir_write <= 1'b0;
              o_cir_sel <= `CIR_OPERAND;
              state <= S_MM_CIR;
            end else begin
              state <= S_MM_RD;
            end
          end else if (bitp == 4'h0) begin
            o_done <= 1'b1;
            o_busy <= 1'b0;
            state <= S_IDLE;
          end else begin
            bitp <= bitp - 4'h1;
          end
        end
        S_MM_RD: begin
          o_cir_req <= 1'b1;
          o_cir_write <= 1'b1;
          o_cir_sel <= `CIR_OPERAND;
          o_cir_wdata <= rf_rdata;
          state <= S_MM_CIR;
        end
        S_MM_CIR: begin
          if (i_cir_ack) begin
            o_cir_req <= 1'b0;
            if (dir) begin
              rf_we <= 1'b1;
              rf_waddr <= rf_index(bitp);
              rf_wdata <= i_cir_rdata;
            end
            mask[bitp] <= 1'b0;
            state <= S_MM_PICK;
          end
        end
        S_EA: begin
          scan_counter <= scan_counter + {28'h000_0000, i_ea_ext, 1'b0};
          cur_addr <= i_ea_addr;
          if (!mode_ok(mode, areg_num, dir)) begin
            o_cir_req <= 1'b1;
            o_cir_write <= 1'b1;
            o_cir_sel <= `CIR_CONTROL;
            o_cir_wdata <= `ABORT_MASK;
            state <= S_ABORT;
          end else begin
            state <= S_AN_RD;
          end
        end
        S_ABORT: begin
          if (i_cir_ack) begin
            o_cir_req <= 1'b0;
            o_line_f <= 1'b1;
            o_done <= 1'b1;
            o_busy <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_AN_RD: begin
          if (mode == `EA_POSTINC || mode == `EA_PREDEC) begin
            an_val <= rf_rdata;
            cur_addr <= rf_rdata;
          end
          o_cir_req <= 1'b1;
          o_cir_write <= 1'b0;
          o_cir_sel <= `CIR_SELECT;
          state <= S_SEL;
        end
        // start of one operand; predecrement lowers the address first
        S_OPND: begin
          bytes_left <= op_len;
          if (mode == `EA_PREDEC) begin
            an_val <= an_val - {24'h00_0000, op_len};
            cur_addr <= an_val - {24'h00_0000, op_len};
          end
          state <= (op_len == 8'h00) ? S_WBACK : S_CHUNK;
        end
        // long words while four or more bytes remain, else one word
        S_CHUNK: begin
          o_word <= (bytes_left < 8'h04);
          o_mem_addr <= cur_addr;
          if (dir) begin
            o_cir_req <= 1'b1;
            o_cir_write <= 1'b0;
            o_cir_sel <= `CIR_OPERAND;
            state <= S_MC_CIR;
          end else begin
            o_mem_req <= 1'b1;
            o_mem_write <= 1'b0;
            state <= S_MC_MEM;
          end
        end
        S_MC_CIR: begin
          if (i_cir_ack) begin
            o_cir_req <= 1'b0;
            if (dir) begin
              o_mem_req <= 1'b1;
              o_mem_write <= 1'b1;
              o_mem_wdata <= i_cir_rdata;
              state <= S_MC_MEM;
            end else begin
              state <= S_WBACK;
            end
          end
        end
        S_MC_MEM: begin
          if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            if (!dir) begin
              o_cir_req <= 1'b1;
              o_cir_write <= 1'b1;
              o_cir_sel <= `CIR_OPERAND;
              o_cir_wdata <= i_mem_rdata;
              state <= S_MC_CIR;
            end else begin
              state <= S_WBACK;
            end
          end
        end
        // advance by the chunk; at operand end either loop or finish
        S_WBACK: begin
          if (bytes_left != 8'h00) begin
            cur_addr <= cur_addr + (o_word ? 32'h0000_0002 : 32'h0000_0004);
            bytes_left <= bytes_left - (o_word ? 8'h02 : 8'h04);
          end
          if (bytes_left > 8'h04 || (bytes_left > 8'h02 && o_word)) begin
            state <= S_CHUNK;
          end else if (ops_left != 5'h01) begin
            ops_left <= ops_left - 5'h01;
            if (mode == `EA_POSTINC) begin
              an_val <= an_val + {24'h00_0000, op_len};
            end
            state <= S_OPND;
          end else begin
            if (mode == `EA_POSTINC || mode == `EA_PREDEC) begin
              rf_we <= 1'b1;
              rf_waddr <= {1'b1, areg_num};
              rf_wdata <= (mode == `EA_POSTINC) ?
                          an_val + {24'h00_0000, op_len} : an_val;
            end
            o_done <= 1'b1;
            o_busy <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // coprocessor_register_transfer

// [verification/cp_xfer_asserts.sv]
`timescale 1ns/1ps
`include "cp_xfer_defs.vh"
// ----------------------------------------
// primitive engine port checker
// ----------------------------------------
module cp_xfer_asserts (
  input wire        i_clk,
  input wire        i_rst,
  input wire        i_prim_valid,
  input wire [15:0] i_prim,
  input wire        i_conditional,
  input wire        o_busy,
  input wire        o_done,
  input wire        o_proto_viol,
  input wire        o_line_f,
  input wire        o_cir_req,
  input wire        o_cir_write,
  input wire [1:0]  o_cir_sel,
  input wire [31:0] o_cir_wdata,
  input wire        i_cir_ack,
  input wire        o_mem_req,
  input wire [31:0] o_mem_addr,
  input wire        i_mem_ack
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // a word offered to an idle engine is taken (enable stays at its reset 1)
  sequence s_take;
    i_prim_valid && !o_busy;
  endsequence
  sequence s_ctrl;
    s_take ##0 i_prim[12:8] == `PT_CTRL_REG;
  endsequence
  sequence s_mcop;
    s_take ##0 i_prim[12:8] == `PT_MULTI_COP;
  endsequence

  a_ctrl_sel_first: assert property (s_ctrl ##0 !(i_conditional && !i_prim[15]) |->
    ##[1:4] (o_cir_req && o_cir_sel == `CIR_SELECT && !o_cir_write))
    else $error("select register not read first");
  a_cond_ctrl_viol: assert property (s_ctrl ##0 (i_conditional && !i_prim[15]) |->
    ##[1:3] o_proto_viol) else $error("flag clear in conditional not refused");
  a_cond_mcop_viol: assert property (s_mcop ##0 i_conditional |->
    ##[1:3] o_proto_viol) else $error("conditional multi transfer not refused");
  a_odd_len_viol: assert property (s_mcop ##0 i_prim[0] |->
    ##[1:3] o_proto_viol) else $error("odd length not refused");
  a_viol_ends_op: assert property (o_proto_viol |-> o_done)
    else $error("violation without done");
  a_abort_mask: assert property (o_cir_req && o_cir_sel == `CIR_CONTROL |->
    o_cir_write && o_cir_wdata == `ABORT_MASK) else $error("bad control write");
  a_linef_done: assert property (o_line_f |-> o_done && !o_proto_viol)
    else $error("emulator exception misplaced");
  a_cir_hold: assert property (o_cir_req && !i_cir_ack |=> o_cir_req &&
    $stable(o_cir_sel) && ($stable(o_cir_wdata) || !o_cir_write))
    else $error("interface request dropped early");
  a_mem_hold: assert property (o_mem_req && !i_mem_ack |=>
    o_mem_req && $stable(o_mem_addr)) else $error("memory request dropped early");
endmodule // cp_xfer_asserts

bind coprocessor_register_transfer cp_xfer_asserts chk (.*);

// [verification/cop_model.sv]
`timescale 1ns/1ps
`include "cp_xfer_defs.vh"
// ----------------------------------------
// coprocessor and memory model
// ----------------------------------------
module cop_model (
  input  wire         i_clk,
  input  wire         i_slow,
  input  wire  [15:0] i_sel_val,
  input  wire  [31:0] i_op_base,
  input  wire         i_req,
  input  wire         i_write,
  input  wire  [1:0]  i_sel,
  input  wire  [31:0] i_wdata,
  output logic        o_ack = 1'b0,
  output logic [31:0] o_rdata = 32'h0,
  input  wire         i_mreq,
  input  wire  [31:0] i_maddr,
  input  wire         i_word,
  input  wire         i_mwrite,
  output logic        o_mack = 1'b0,
  output logic [31:0] o_mrdata = 32'h0
);
  logic [31:0] op_q[$];
  logic [31:0] ma_q[$];
  int          rd_n = 0;
  int          cc = 0;
  int          mc = 0;

  // interface registers; idle data keeps toggling so stale values never match
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (cc < (i_slow ? 3 : 0)) begin
        cc <= cc + 1;
      end else begin
        cc <= 0;
        o_ack <= 1'b1;
        if (i_write)
          op_q.push_back(i_wdata);
        else if (i_sel == `CIR_SELECT)
          o_rdata <= {16'h0, i_sel_val};
        else begin
          o_rdata <= i_op_base + 4 * rd_n;
          rd_n <= rd_n + 1;
        end
      end
    end
  end

  // memory logs address with the word flag in bit 0, the write flag in bit 31
  always @(posedge i_clk) begin
    o_mack <= 1'b0;
    o_mrdata <= ~o_mrdata;
    if (i_mreq && !o_mack) begin
      if (mc < (i_slow ? 2 : 0)) begin
        mc <= mc + 1;
      end else begin
        mc <= 0;
        o_mack <= 1'b1;
        ma_q.push_back(i_maddr | i_word | {i_mwrite, 31'h0});
        o_mrdata <= i_maddr ^ 32'h5A00_0000;
      end
    end
  end
endmodule // cop_model

// [verification/tb_top.sv]
`timescale 1ns/1ps
`include "cp_xfer_defs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        i_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic        i_prim_valid = 0, i_conditional = 0, i_cir_ack, i_mem_ack, slow = 0;
  logic        o_pready, o_pslverr, o_busy, o_done, o_proto_viol, o_line_f, o_word;
  logic        o_cir_req, o_cir_write, o_mem_req, o_mem_write, pv, lf, err;
  logic [7:0]  i_paddr = 0;
  logic [15:0] i_prim = 0, sel_val = 0;
  logic [2:0]  i_ea_mode = 0, i_ea_reg = 0, i_ea_ext = 0;
  logic [1:0]  o_cir_sel;
  logic [31:0] i_pwdata = 0, i_ea_addr = 0, o_prdata, i_cir_rdata, i_mem_rdata;
  logic [31:0] o_cir_wdata, o_mem_addr, o_mem_wdata, rd, e, a, ev[8];
  logic [31:0] base = 32'h1000_0000;
  logic [15:0] cs[8] = '{`CS_SFC, `CS_DFC, `CS_CACHE_CTL, `CS_USP, `CS_VBR,
                         `CS_CACHE_ADDR, `CS_MSP, `CS_ISP};
  int          moff[4] = '{0, 7, 8, 15};
  int          pinc[4] = '{0, 5, 6, 11};
  int          pdec[4] = '{6, 11, 0, 5};
  int          num_errors = 0, n_compared = 0, k, n;

  coprocessor_register_transfer uut (.*);
  cop_model cpm (.i_clk(i_clk), .i_slow(slow), .i_sel_val(sel_val), .i_op_base(base),
    .i_req(o_cir_req), .i_write(o_cir_write), .i_sel(o_cir_sel), .i_wdata(o_cir_wdata),
    .o_ack(i_cir_ack), .o_rdata(i_cir_rdata), .i_mreq(o_mem_req), .i_maddr(o_mem_addr),
    .i_word(o_word), .i_mwrite(o_mem_write), .o_mack(i_mem_ack), .o_mrdata(i_mem_rdata));

  // 40 MHz
  initial forever #12.5 i_clk = ~i_clk;

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task hang;
    num_errors++;
    print_verdict;
  endtask

  // apb setup then access; held until pready is sampled
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int t;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= ad;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    t = 0;
    do @(posedge i_clk); while (o_pready !== 1'b1 && ++t < 50);
    if (t >= 50) hang;
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // offer one primitive word, collect exception pulses until done
  task prim(input logic [15:0] w, input logic c);
    int t;
    @(posedge i_clk);
    i_prim <= w;
    i_conditional <= c;
    i_prim_valid <= 1'b1;
    @(posedge i_clk);
    i_prim_valid <= 1'b0;
    pv = 0;
    lf = 0;
    t = 0;
    do begin
      @(posedge i_clk);
      pv |= o_proto_viol;
      lf |= o_line_f;
    end while (o_done !== 1'b1 && ++t < 400);
    if (t >= 400) hang;
  endtask

  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    apb(0, `OFS_CTRL, 0);
    `CHK(rd, `CTRL_RESET)
    apb(0, `OFS_SCAN, 0);
    `CHK(rd, `SCAN_RESET)
    apb(0, 8'h10, 0);
    `CHK(err, 1'b1)
    $display("test registers done");
    for (k = 0; k < 8; k++) begin
      slow <= k[0];
      sel_val <= cs[k];
      ev[k] = base + 4 * cpm.rd_n;
      prim({3'b101, `PT_CTRL_REG, 8'h00}, 1'b0);
      `CHK(pv, 1'b0)
    end
    for (k = 0; k < 8; k++) begin
      sel_val <= cs[k];
      prim({3'b100, `PT_CTRL_REG, 8'h00}, 1'b0);
      `CHK(cpm.op_q[$], ev[k])
    end
    n = cpm.op_q.size();
    sel_val <= 16'h0805;
    prim({3'b100, `PT_CTRL_REG, 8'h00}, 1'b0);
    `CHK(pv, 1'b1)
    `CHK(cpm.op_q.size(), n)
    apb(0, `OFS_STATUS, 0);
    `CHK(rd[`ST_PV_BIT], 1'b1)
    apb(1, `OFS_STATUS, 32'h2);
    apb(0, `OFS_STATUS, 0);
    `CHK(rd[`ST_PV_BIT], 1'b0)
    prim({3'b000, `PT_CTRL_REG, 8'h00}, 1'b1);
    `CHK(pv, 1'b1)
    prim({3'b000, `PT_MULTI_MAIN, 8'h00}, 1'b1);
    `CHK(pv, 1'b1)
    $display("test control registers done");
    // load all sixteen main registers, read four back in order
    sel_val <= 16'hFFFF;
    e = base + 4 * cpm.rd_n;
    prim({3'b101, `PT_MULTI_MAIN, 8'h00}, 1'b0);
    sel_val <= 16'h8181;
    prim({3'b100, `PT_MULTI_MAIN, 8'h00}, 1'b0);
    for (k = 0; k < 4; k++)
      `CHK(cpm.op_q[cpm.op_q.size() - 4 + k], e + 4 * moff[k])
    $display("test main registers done");
    // six-byte operands through address register 1
    a = e + 56;
    n = cpm.ma_q.size();
    i_ea_mode <= `EA_POSTINC;
    i_ea_reg <= 3'h1;
    sel_val <= 16'h0300;
    prim({3'b100, `PT_MULTI_COP, 8'h06}, 1'b0);
    for (k = 0; k < 4; k++)
      `CHK(cpm.ma_q[n + k], a + pinc[k])
    apb(0, `OFS_COUNT, 0);
    `CHK(rd, 32'h2)
    i_ea_mode <= `EA_PREDEC;
    sel_val <= 16'h0003;
    prim({3'b101, `PT_MULTI_COP, 8'h06}, 1'b0);
    for (k = 0; k < 4; k++)
      `CHK(cpm.ma_q[n + 4 + k], (a + pdec[k]) | 32'h8000_0000)
    sel_val <= 16'h0002;
    prim({3'b100, `PT_MULTI_MAIN, 8'h00}, 1'b0);
    `CHK(cpm.op_q[$], a)
    // control mode, one extension word, empty mask
    n = cpm.ma_q.size();
    i_ea_mode <= `EA_SPECIAL;
    i_ea_reg <= 3'h0;
    i_ea_ext <= 3'h1;
    i_ea_addr <= 32'h0000_4000;
    sel_val <= 16'h0000;
    prim({3'b100, `PT_MULTI_COP, 8'h06}, 1'b0);
    `CHK(cpm.ma_q.size(), n)
    apb(0, `OFS_SCAN, 0);
    `CHK(rd, 32'h2)
    i_ea_ext <= 3'h0;
    i_ea_mode <= 3'h0;
    prim({3'b100, `PT_MULTI_COP, 8'h06}, 1'b0);
    `CHK(lf, 1'b1)
    `CHK(cpm.op_q[$], `ABORT_MASK)
    i_ea_mode <= `EA_POSTINC;
    prim({3'b101, `PT_MULTI_COP, 8'h06}, 1'b0);
    `CHK(lf, 1'b1)
    prim({3'b100, `PT_MULTI_COP, 8'h05}, 1'b0);
    `CHK(pv, 1'b1)
    prim({3'b100, `PT_MULTI_COP, 8'h06}, 1'b1);
    `CHK(pv, 1'b1)
    $display("test coprocessor transfers done");
    print_verdict;
  end
endmodule // tb_top
